// *** hw/mip_edge_detect.sv ***
// Pin synchroniser and selectable rising/falling edge detector
`timescale 1ns/1ps
module mip_edge_detect (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [mip_pkg::N_EDGE-1:0] pins,
    input wire logic [mip_pkg::N_EDGE-1:0] rise_sel,
    output logic [mip_pkg::N_EDGE-1:0] edge_evt
);

    mip_pkg::mip_edge_s q;
    mip_pkg::mip_edge_s d;

    // Two flops for the crossing, a third to compare against
    always_comb
    begin
        d = q;
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.arm != mip_pkg::ARM_DONE)
        begin
            d.arm = q.arm + 2'h1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // Edges are held off until the chain holds real pin levels, so that
    // the reset value of the chain never fakes an edge
    genvar i;
    generate
        for (i = 0; i < mip_pkg::N_EDGE; i++)
        begin : g_edge
            assign edge_evt[i] = (q.arm == mip_pkg::ARM_DONE) &&
                (rise_sel[i] ? (q.s2[i] & ~q.s3[i]) : (~q.s2[i] & q.s3[i]));
        end
    endgenerate

endmodule

// *** hw/mip_pkg.sv ***
// Constants, register map and carrier types of the interrupt prioritizer
package mip_pkg;

    // Register indices; the AXI byte address is four times the index
    localparam int ADDR_W = 18;
    localparam logic [15:0] IDX_WAKE_SEL = 16'hff90;
    localparam logic [15:0] IDX_PIN_SEL = 16'hfff2;
    localparam logic [15:0] IDX_EN1 = 16'hfff3;
    localparam logic [15:0] IDX_EN2 = 16'hfff4;
    localparam logic [15:0] IDX_FLG1 = 16'hfff6;
    localparam logic [15:0] IDX_FLG2 = 16'hfff7;
    localparam logic [15:0] IDX_WFLG = 16'hfff9;

    // Reset values
    localparam logic [7:0] RST_WAKE_SEL = 8'h00;
    localparam logic [7:0] RST_PIN_SEL = 8'he0;
    localparam logic [7:0] RST_EN = 8'h00;
    localparam logic [7:0] RST_FLG1 = 8'h20;
    localparam logic [7:0] RST_FLG2 = 8'h00;
    localparam logic [7:0] RST_WFLG = 8'h00;

    // Fixed-one upper bits of the pin edge-select register
    localparam logic [2:0] PIN_SEL_TOP = 3'h7;
    // Flag bits of the first flag register that hardware may set
    localparam logic [7:0] FLG1_LIVE = 8'h9f;
    // Flag bits of the second flag register that hardware may set
    localparam logic [7:0] FLG2_LIVE = 8'hdf;

    // Bit positions in the enable and flag registers
    localparam int B1_TA = 7;
    localparam int B1_WP = 5;
    localparam int B2_EC = 0;
    localparam int B2_TC = 1;
    localparam int B2_TFL = 2;
    localparam int B2_TFH = 3;
    localparam int B2_TG = 4;
    localparam int B2_AD = 6;
    localparam int B2_DT = 7;

    // Pin counts and position of the conversion trigger in the edge vector
    localparam int N_PIN = 5;
    localparam int N_WAKE = 8;
    localparam int N_EDGE = 14;
    localparam int E_TRIG = 13;

    // Vector numbers
    localparam logic [4:0] VEC_RESET = 5'h00;
    localparam logic [4:0] VEC_PIN0 = 5'h04;
    localparam logic [4:0] VEC_WAKE = 5'h09;
    localparam logic [4:0] VEC_TA = 5'h0b;
    localparam logic [4:0] VEC_EC = 5'h0c;
    localparam logic [4:0] VEC_TC = 5'h0d;
    localparam logic [4:0] VEC_TFL = 5'h0e;
    localparam logic [4:0] VEC_TFH = 5'h0f;
    localparam logic [4:0] VEC_TG = 5'h10;
    localparam logic [4:0] VEC_SER1 = 5'h11;
    localparam logic [4:0] VEC_SER2 = 5'h12;
    localparam logic [4:0] VEC_AD = 5'h13;
    localparam logic [4:0] VEC_DT = 5'h14;
    localparam int VEC_FIRST = 4;
    localparam int VEC_LAST = 20;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Edge detector start-up: cycles before edges are trusted
    localparam logic [1:0] ARM_DONE = 2'h3;

    typedef enum {
        SEL_NONE, SEL_WAKE_SEL, SEL_PIN_SEL, SEL_EN1, SEL_EN2,
        SEL_FLG1, SEL_FLG2, SEL_WFLG
    } mip_sel_e;

    // Event pulses from the on-chip peripherals, 23 in all
    typedef struct packed {
        logic timer_a_ovf;
        logic async_cnt_ovf;
        logic timer_c_ovf;
        logic timer_c_udf;
        logic [1:0] timer_f_low;  // [1] compare match, [0] overflow
        logic [1:0] timer_f_high; // [1] compare match, [0] overflow
        logic [1:0] timer_g;      // [1] input capture, [0] overflow
        logic [5:0] serial_channel_one;
        logic [5:0] serial_channel_two;
        logic adc_end;
    } mip_periph_s;

    // Edge detector state
    typedef struct packed {
        logic [N_EDGE-1:0] s1;
        logic [N_EDGE-1:0] s2;
        logic [N_EDGE-1:0] s3;
        logic [1:0] arm;
    } mip_edge_s;

    // Whole state of the prioritizer
    typedef struct packed {
        logic aw_ok;
        logic w_ok;
        logic [ADDR_W-1:0] aw_addr;
        logic [7:0] w_data;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] wake_sel;
        logic [4:0] pin_sel;
        logic [7:0] en1;
        logic [7:0] en2;
        logic [7:0] flg1;
        logic [7:0] flg2;
        logic [7:0] wflg;
        logic i_bit;
        logic irq_req;
        logic [4:0] vec;
        logic [15:0] vaddr;
        logic conv_trig;
    } mip_state_s;

endpackage

// *** hw/mip_prioritizer.sv ***
// Interrupt prioritizer: edge sensing, flags, enables, vector selection
//
// How it works
// - Takes 5 request pins, 8 wake-up pins and 23 peripheral events.
// - Only the highest-priority pending, enabled request reaches the CPU.
// - Mask bit set: flags still latch, but no request is offered.
// - Every request pin and wake-up pin picks rising or falling edge.
// - Vector numbers 1 to 3 and 10 are never given to any source.
// - Timer C overflow and underflow share vector 13.
// - Low 8-bit timer compare and overflow share vector 14.
// - High 8-bit timer compare and overflow share vector 15.
// - Capture timer capture and overflow share vector 16.
// - All six first serial channel events share vector 17.
// - All six second serial channel events share vector 18.
// - Flags clear only by writing 0; writing 1 never sets a flag.
// - Edge-select bits 7 to 5 read as 1 and ignore writes.
// - Edge-select bit 4 covers request pin 4 and the trigger pin.
// - Reset leaves the CPU mask bit at 1.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module mip_prioritizer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [mip_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [mip_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [mip_pkg::N_PIN-1:0] irq_pin,
    input wire logic [mip_pkg::N_WAKE-1:0] wakeup_pin,
    input wire logic conv_trigger_pin,
    input wire mip_pkg::mip_periph_s periph_evt,
    input wire logic sleep_direct_evt,
    input wire logic cpu_irq_ack,
    input wire logic cpu_mask_wr,
    input wire logic cpu_mask_val,
    output logic cpu_irq_req,
    output logic [4:0] cpu_irq_vector,
    output logic [15:0] cpu_irq_vaddr,
    output logic cpu_mask,
    output logic conv_trigger_evt
);

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Address to register; unaligned or unknown words map to nothing
    function automatic mip_pkg::mip_sel_e decode(
        input logic [mip_pkg::ADDR_W-1:0] addr
    );
        mip_pkg::mip_sel_e s;
        s = mip_pkg::SEL_NONE;
        if (addr[1:0] == 2'h0)
        begin
            case (addr[mip_pkg::ADDR_W-1:2])
                mip_pkg::IDX_WAKE_SEL: s = mip_pkg::SEL_WAKE_SEL;
                mip_pkg::IDX_PIN_SEL: s = mip_pkg::SEL_PIN_SEL;
                mip_pkg::IDX_EN1: s = mip_pkg::SEL_EN1;
                mip_pkg::IDX_EN2: s = mip_pkg::SEL_EN2;
                mip_pkg::IDX_FLG1: s = mip_pkg::SEL_FLG1;
                mip_pkg::IDX_FLG2: s = mip_pkg::SEL_FLG2;
                mip_pkg::IDX_WFLG: s = mip_pkg::SEL_WFLG;
                default: s = mip_pkg::SEL_NONE;
            endcase
        end
        return s;
    endfunction

    // Read view of each register
    function automatic logic [7:0] read_reg(
        input mip_pkg::mip_sel_e s,
        input mip_pkg::mip_state_s st
    );
        logic [7:0] v;
        v = 8'h00;
        case (s)
            mip_pkg::SEL_WAKE_SEL: v = st.wake_sel;
            mip_pkg::SEL_PIN_SEL: v = {mip_pkg::PIN_SEL_TOP, st.pin_sel};
            mip_pkg::SEL_EN1: v = st.en1;
            mip_pkg::SEL_EN2: v = st.en2;
            mip_pkg::SEL_FLG1: v = st.flg1;
            mip_pkg::SEL_FLG2: v = st.flg2;
            mip_pkg::SEL_WFLG: v = st.wflg;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // Lowest pending vector number wins
    function automatic logic [4:0] encode(
        input logic [mip_pkg::VEC_LAST:0] p
    );
        logic [4:0] v;
        v = mip_pkg::VEC_RESET;
        for (int k = mip_pkg::VEC_LAST; k >= mip_pkg::VEC_FIRST; k--)
        begin
            if (p[k])
            begin
                v = 5'(k);
            end
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin edge sensing

    logic [mip_pkg::N_EDGE-1:0] edge_evt;
    logic [mip_pkg::N_EDGE-1:0] rise_sel;
    mip_pkg::mip_state_s q;
    mip_pkg::mip_state_s d;

    // Pin 4 and the trigger pin share one select bit
    assign rise_sel = {q.pin_sel[4], q.wake_sel, q.pin_sel};

    mip_edge_detect u_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .pins({conv_trigger_pin, wakeup_pin, irq_pin}),
        .rise_sel(rise_sel),
        .edge_evt(edge_evt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    logic wr_go;
    mip_pkg::mip_sel_e wr_sel;
    mip_pkg::mip_sel_e rd_sel;
    logic [7:0] set1;
    logic [7:0] set2;
    logic [7:0] keep1;
    logic [7:0] keep2;
    logic [7:0] keepw;
    logic [mip_pkg::VEC_LAST:0] pend;

    always_comb
    begin
        d = q;

        // Address and data may arrive in either order; each is held
        // until both are in, then the write happens with the response
        if (s_axi_awvalid && q.awready)
        begin
            d.aw_ok = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready)
        begin
            d.w_ok = 1'b1;
            d.w_data = s_axi_wdata[7:0];
            d.w_lane0 = s_axi_wstrb[0];
        end
        if (s_axi_bready && q.bvalid)
        begin
            d.bvalid = 1'b0;
        end
        wr_go = q.aw_ok && q.w_ok && !q.bvalid;
        wr_sel = mip_pkg::SEL_NONE;
        if (wr_go)
        begin
            d.aw_ok = 1'b0;
            d.w_ok = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = (decode(q.aw_addr) == mip_pkg::SEL_NONE) ?
                mip_pkg::RESP_SLVERR : mip_pkg::RESP_OKAY;
            // Only the low byte lane carries register bits
            wr_sel = q.w_lane0 ? decode(q.aw_addr) : mip_pkg::SEL_NONE;
        end
        // No new write is taken until the response has gone
        d.awready = !d.aw_ok && !d.bvalid;
        d.wready = !d.w_ok && !d.bvalid;

        // Read: one at a time, answered in the cycle after the address
        rd_sel = decode(s_axi_araddr);
        if (s_axi_rready && q.rvalid)
        begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready)
        begin
            d.rvalid = 1'b1;
            d.rdata = {24'h000000, read_reg(rd_sel, q)};
            d.rresp = (rd_sel == mip_pkg::SEL_NONE) ?
                mip_pkg::RESP_SLVERR : mip_pkg::RESP_OKAY;
        end
        d.arready = !d.rvalid;

        // Configuration writes; upper edge-select bits are not stored
        case (wr_sel)
            mip_pkg::SEL_WAKE_SEL: d.wake_sel = q.w_data;
            mip_pkg::SEL_PIN_SEL: d.pin_sel = q.w_data[4:0];
            mip_pkg::SEL_EN1: d.en1 = q.w_data;
            mip_pkg::SEL_EN2: d.en2 = q.w_data;
            default: d.wake_sel = q.wake_sel;
        endcase

        // Hardware events that raise flags
        set1 = 8'h00;
        set1[mip_pkg::N_PIN-1:0] = edge_evt[mip_pkg::N_PIN-1:0];
        set1[mip_pkg::B1_TA] = periph_evt.timer_a_ovf;
        set2 = 8'h00;
        set2[mip_pkg::B2_EC] = periph_evt.async_cnt_ovf;
        set2[mip_pkg::B2_TC] = periph_evt.timer_c_ovf |
            periph_evt.timer_c_udf;
        set2[mip_pkg::B2_TFL] = |periph_evt.timer_f_low;
        set2[mip_pkg::B2_TFH] = |periph_evt.timer_f_high;
        set2[mip_pkg::B2_TG] = |periph_evt.timer_g;
        set2[mip_pkg::B2_AD] = periph_evt.adc_end;
        set2[mip_pkg::B2_DT] = sleep_direct_evt;

        // A written 0 clears, a written 1 keeps; an event in the same
        // cycle as the clear still lands, so none is lost
        keep1 = (wr_sel == mip_pkg::SEL_FLG1) ? q.w_data : 8'hff;
        keep2 = (wr_sel == mip_pkg::SEL_FLG2) ? q.w_data : 8'hff;
        keepw = (wr_sel == mip_pkg::SEL_WFLG) ? q.w_data : 8'hff;
        d.flg1 = (((q.flg1 & keep1) | set1) & mip_pkg::FLG1_LIVE) |
            mip_pkg::RST_FLG1;
        d.flg2 = ((q.flg2 & keep2) | set2) & mip_pkg::FLG2_LIVE;
        d.wflg = (q.wflg & keepw) |
            edge_evt[mip_pkg::N_PIN +: mip_pkg::N_WAKE];

        // Trigger edge goes on to the converter as a pulse
        d.conv_trig = edge_evt[mip_pkg::E_TRIG];

        // Mask bit: CPU may load it; taking an interrupt sets it
        if (cpu_mask_wr)
        begin
            d.i_bit = cpu_mask_val;
        end
        if (cpu_irq_ack)
        begin
            d.i_bit = 1'b1;
        end

        // Pending, enabled requests by vector number; serial channels
        // keep their own flags and enables, so they pass as levels
        pend = '0;
        for (int k = 0; k < mip_pkg::N_PIN; k++)
        begin
            pend[mip_pkg::VEC_PIN0 + 5'(k)] = q.flg1[k] & q.en1[k];
        end
        pend[mip_pkg::VEC_WAKE] = (|q.wflg) & q.en1[mip_pkg::B1_WP];
        pend[mip_pkg::VEC_TA] = q.flg1[mip_pkg::B1_TA] &
            q.en1[mip_pkg::B1_TA];
        pend[mip_pkg::VEC_EC] = q.flg2[mip_pkg::B2_EC] &
            q.en2[mip_pkg::B2_EC];
        pend[mip_pkg::VEC_TC] = q.flg2[mip_pkg::B2_TC] &
            q.en2[mip_pkg::B2_TC];
        pend[mip_pkg::VEC_TFL] = q.flg2[mip_pkg::B2_TFL] &
            q.en2[mip_pkg::B2_TFL];
        pend[mip_pkg::VEC_TFH] = q.flg2[mip_pkg::B2_TFH] &
            q.en2[mip_pkg::B2_TFH];
        pend[mip_pkg::VEC_TG] = q.flg2[mip_pkg::B2_TG] &
            q.en2[mip_pkg::B2_TG];
        pend[mip_pkg::VEC_SER1] = |periph_evt.serial_channel_one;
        pend[mip_pkg::VEC_SER2] = |periph_evt.serial_channel_two;
        pend[mip_pkg::VEC_AD] = q.flg2[mip_pkg::B2_AD] &
            q.en2[mip_pkg::B2_AD];
        pend[mip_pkg::VEC_DT] = q.flg2[mip_pkg::B2_DT] &
            q.en2[mip_pkg::B2_DT];
        // Vectors 1 to 3 and 10 stay unconnected
        pend[mip_pkg::VEC_FIRST-1:0] = '0;

        // The new mask value gates at once, so an acknowledged request
        // never shows again in the cycle after the acknowledge
        d.irq_req = (|pend) && !d.i_bit;
        d.vec = (|pend) ? encode(pend) : mip_pkg::VEC_RESET;
        d.vaddr = {10'h000, d.vec, 1'b0};
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
            q.wake_sel <= mip_pkg::RST_WAKE_SEL;
            q.pin_sel <= mip_pkg::RST_PIN_SEL[4:0];
            q.en1 <= mip_pkg::RST_EN;
            q.en2 <= mip_pkg::RST_EN;
            q.flg1 <= mip_pkg::RST_FLG1;
            q.flg2 <= mip_pkg::RST_FLG2;
            q.wflg <= mip_pkg::RST_WFLG;
            q.i_bit <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign cpu_irq_req = q.irq_req;
    assign cpu_irq_vector = q.vec;
    assign cpu_irq_vaddr = q.vaddr;
    assign cpu_mask = q.i_bit;
    assign conv_trigger_evt = q.conv_trig;

endmodule

// *** verification/mip_cpu_model.sv ***
// CPU core model: acknowledges requests and loads the mask bit
`timescale 1ns/1ps
module mip_cpu_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cpu_irq_req,
    input wire logic auto_ack,
    input wire logic [3:0] ack_delay,
    input wire logic unmask,
    output logic cpu_irq_ack,
    output logic cpu_mask_wr,
    output logic cpu_mask_val
);
logic [3:0] wait_q;
// Acknowledge after a delay, as a core finishing its instruction would
always @(posedge aclk)
begin
    cpu_irq_ack <= 1'b0;
    cpu_mask_wr <= unmask;
    cpu_mask_val <= 1'b0;
    if (!aresetn || !cpu_irq_req || cpu_irq_ack)
        wait_q <= 4'h0;
    else if (auto_ack && wait_q == ack_delay)
        cpu_irq_ack <= 1'b1;
    else
        wait_q <= wait_q + 4'h1;
end
endmodule

// *** verification/mip_prioritizer_assertions.sv ***
// Concurrent checks on the interrupt prioritizer ports
`timescale 1ns/1ps
module mip_prioritizer_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cpu_irq_ack,
    input wire logic cpu_mask_wr,
    input wire logic cpu_mask_val,
    input wire logic cpu_irq_req,
    input wire logic [4:0] cpu_irq_vector,
    input wire logic [15:0] cpu_irq_vaddr,
    input wire logic cpu_mask
);
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
////////////////////////////////////////////////////////////////////////////
// Both write halves taken at one edge
sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
// Acknowledge followed by the mask bit standing set
sequence s_acked;
    cpu_irq_ack ##1 cpu_mask;
endsequence
////////////////////////////////////////////////////////////////////////////
a_reset_mask: assert property ($rose(aresetn) |-> cpu_mask)
    else $error("mask bit not set after reset");
a_ack_drops: assert property (s_acked |-> ##1 !cpu_irq_req)
    else $error("request after ack");
a_mask_blocks: assert property (cpu_mask && $past(cpu_mask) |-> !cpu_irq_req)
    else $error("request while masked");
a_mask_load: assert property (cpu_mask_wr && !cpu_irq_ack |=>
    cpu_mask == $past(cpu_mask_val))
    else $error("mask bit load lost");
a_vaddr_twice: assert property (cpu_irq_vaddr ==
    {10'h0, cpu_irq_vector, 1'b0})
    else $error("bad vector address");
a_vec_legal: assert property (cpu_irq_req |->
    cpu_irq_vector inside {[5'h04:5'h09], [5'h0b:5'h14]})
    else $error("reserved vector offered");
a_write_resp: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer late");
a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule
bind mip_prioritizer mip_prioritizer_assertions
    mip_prioritizer_assertions_inst (.*);

// *** verification/mip_prioritizer_tb.sv ***
// Self-checking bench for the interrupt prioritizer
`timescale 1ns/1ps
module mip_prioritizer_tb;
logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
logic s_axi_arready, s_axi_rvalid, s_axi_rready, conv_trigger_pin;
logic sleep_direct_evt, cpu_irq_ack, cpu_mask_wr, cpu_mask_val;
logic cpu_irq_req, cpu_mask, conv_trigger_evt, auto_ack, unmask;
logic [17:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, s_axi_rdata;
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp, r;
logic [4:0] irq_pin, cpu_irq_vector;
logic [7:0] wakeup_pin;
logic [13:0] pins;
logic [15:0] cpu_irq_vaddr;
logic [31:0] d;
mip_pkg::mip_periph_s periph_evt;
int fail_count = 0;
int n_tests = 0;
int trig_n = 0;
localparam logic [15:0] IDXS [7] = '{16'hff90, 16'hfff2, 16'hfff3,
    16'hfff4, 16'hfff6, 16'hfff7, 16'hfff9};
localparam logic [7:0] RSTS [7] = '{8'h00, 8'he0, 8'h00, 8'h00, 8'h20,
    8'h00, 8'h00};
assign {conv_trigger_pin, wakeup_pin, irq_pin} = pins;
mip_prioritizer mip_prioritizer_inst (.*);
mip_cpu_model mip_cpu_model_inst (.*, .ack_delay(4'h2));
////////////////////////////////////////////////////////////////////////////
// 25 MHz clock
initial
begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
end
// Count one-cycle trigger pulses
always @(posedge aclk)
    if (conv_trigger_evt === 1'b1) trig_n++;
////////////////////////////////////////////////////////////////////////////
task automatic summarize;
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
        fail_count++;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
// Request, vector and vector address in one word
task automatic chk_irq(input logic q, input logic [4:0] v);
    chk({10'h0, cpu_irq_req, cpu_irq_vector, cpu_irq_vaddr},
        {10'h0, q, v, 10'h0, v, 1'b0});
endtask
task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
endtask
// Address and data offered together; bready and rready stay high
task automatic wr(input logic [15:0] idx, input logic [7:0] v);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
endtask
task automatic rd(input logic [15:0] idx);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do
    begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
endtask
task automatic wchk(input logic [15:0] idx, input logic [7:0] v);
    wr(idx, v);
    chk({30'h0, r}, {30'h0, mip_pkg::RESP_OKAY});
endtask
task automatic rchk(input logic [15:0] idx, input logic [7:0] e);
    rd(idx);
    chk({r, d[29:0]}, {mip_pkg::RESP_OKAY, 22'h0, e});
endtask
task automatic flags_chk(input logic [13:0] a);
    rchk(mip_pkg::IDX_FLG1, {3'h1, a[4:0]});
    rchk(mip_pkg::IDX_WFLG, a[12:5]);
endtask
// Each pin falls then rises; only the selected edge may latch a flag
task automatic edge_round(input logic [4:0] ps, input logic [7:0] ws);
    logic [13:0] acc = 14'h0;
    logic [13:0] rise = {ps[4], ws, ps};
    int n;
    wchk(mip_pkg::IDX_PIN_SEL, {3'h0, ps});
    rchk(mip_pkg::IDX_PIN_SEL, {3'h7, ps});
    wchk(mip_pkg::IDX_WAKE_SEL, ws);
    for (int i = 0; i < 14; i++)
    begin
        n = trig_n;
        pins[i] <= 1'b0;
        cyc(8);
        acc[i] = !rise[i];
        flags_chk(acc);
        chk(trig_n - n, {31'h0, i == 13 && !rise[i]});
        pins[i] <= 1'b1;
        cyc(8);
        acc[i] = 1'b1;
        flags_chk(acc);
        chk(trig_n - n, {31'h0, i == 13});
    end
    wchk(mip_pkg::IDX_FLG1, 8'h00);
    wchk(mip_pkg::IDX_WFLG, 8'h00);
endtask
function automatic logic [4:0] exp_vec(input int b);
    if (b == 0) return 5'h13;
    if (b < 7) return 5'h12;
    if (b < 13) return 5'h11;
    if (b < 15) return 5'h10;
    if (b < 17) return 5'h0f;
    if (b < 19) return 5'h0e;
    if (b < 21) return 5'h0d;
    return b == 21 ? 5'h0c : 5'h0b;
endfunction
////////////////////////////////////////////////////////////////////////////
// Watchdog well beyond the expected run
initial
begin
    repeat (40000) @(posedge aclk);
    fail_count++;
    summarize();
end
// Main sequence
initial
begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h1;
    {s_axi_arvalid, s_axi_rready, sleep_direct_evt, auto_ack} = 4'h4;
    {unmask, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 69'h0;
    s_axi_wstrb = 4'h1;
    pins = 14'h3fff;
    periph_evt = 23'h0;
    cyc(3);
    aresetn <= 1'b1;
    cyc(1);
    chk({31'h0, cpu_mask}, 32'h1);
    for (int i = 0; i < 7; i++) rchk(IDXS[i], RSTS[i]);
    rd(16'hfff5);
    chk({r, d[29:0]}, {mip_pkg::RESP_SLVERR, 30'h0});
    wr(16'hfff5, 8'h00);
    chk({30'h0, r}, {30'h0, mip_pkg::RESP_SLVERR});
    wchk(mip_pkg::IDX_PIN_SEL, 8'h00);
    rchk(mip_pkg::IDX_PIN_SEL, 8'he0);
    for (int i = 4; i < 7; i++)
    begin
        wchk(IDXS[i], 8'hff);
        rchk(IDXS[i], RSTS[i]);
    end
    edge_round(5'h10, 8'h5a);
    edge_round(5'h0f, 8'ha5);
    wchk(mip_pkg::IDX_EN1, 8'hff);
    wchk(mip_pkg::IDX_EN2, 8'hff);
    periph_evt <= 23'h400000;
    cyc(1);
    periph_evt <= 23'h0;
    cyc(3);
    rchk(mip_pkg::IDX_FLG1, 8'ha0);
    chk_irq(1'b0, mip_pkg::VEC_TA);
    unmask <= 1'b1;
    cyc(1);
    unmask <= 1'b0;
    cyc(4);
    chk_irq(1'b1, mip_pkg::VEC_TA);
    wchk(mip_pkg::IDX_FLG1, 8'h00);
    // Every peripheral event alone; serial events are held as levels
    for (int b = 0; b < 23; b++)
    begin
        periph_evt <= 23'h1 << b;
        cyc(1);
        if (b < 1 || b > 12) periph_evt <= 23'h0;
        cyc(3);
        chk_irq(1'b1, exp_vec(b));
        periph_evt <= 23'h0;
        wchk(mip_pkg::IDX_FLG1, 8'h00);
        wchk(mip_pkg::IDX_FLG2, 8'h00);
        cyc(3);
        chk_irq(1'b0, 5'h00);
    end
    // All at once, then peeled off by clearing flags and dropping the serial levels
    sleep_direct_evt <= 1'b1;
    periph_evt <= 23'h7fffff;
    cyc(1);
    sleep_direct_evt <= 1'b0;
    periph_evt <= 23'h1ffe;
    cyc(3);
    chk_irq(1'b1, mip_pkg::VEC_TA);
    wchk(mip_pkg::IDX_FLG1, 8'h00);
    cyc(2);
    chk_irq(1'b1, mip_pkg::VEC_EC);
    for (int k = 0; k < 5; k++)
    begin
        wchk(mip_pkg::IDX_FLG2, 8'hfe << k);
        cyc(2);
        chk_irq(1'b1, k == 4 ? 5'h11 : 5'h0d + k[4:0]);
    end
    periph_evt <= 23'h7e;
    cyc(3);
    chk_irq(1'b1, mip_pkg::VEC_SER2);
    periph_evt <= 23'h0;
    cyc(3);
    chk_irq(1'b1, mip_pkg::VEC_AD);
    wchk(mip_pkg::IDX_FLG2, 8'h80);
    cyc(2);
    chk_irq(1'b1, mip_pkg::VEC_DT);
    wchk(mip_pkg::IDX_FLG2, 8'h00);
    // Pins: all request pins and one wake pin fall together
    wchk(mip_pkg::IDX_PIN_SEL, 8'h00);
    wchk(mip_pkg::IDX_WAKE_SEL, 8'h00);
    pins <= 14'h3ee0;
    cyc(8);
    chk_irq(1'b1, mip_pkg::VEC_PIN0);
    for (int k = 0; k < 5; k++)
    begin
        wchk(mip_pkg::IDX_FLG1, 8'hfe << k);
        cyc(2);
        chk_irq(1'b1, 5'h05 + k[4:0]);
    end
    pins <= 14'h3fff;
    auto_ack <= 1'b1;
    cyc(8);
    chk({31'h0, cpu_mask}, 32'h1);
    chk_irq(1'b0, mip_pkg::VEC_WAKE);
    auto_ack <= 1'b0;
    wchk(mip_pkg::IDX_WFLG, 8'h00);
    summarize();
end
endmodule
